/* design/cpu_irq_halt_reset_sequencer.sv */
`timescale 1ns/1ns
module cpu_irq_halt_reset_sequencer
    import seq_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        irq_request_n_i,
    input  wire logic        nmi_request_n_i,
    input  wire logic        stall_request_n_i,
    input  wire logic        bus_takeover_request_n_i,
    input  wire logic        emulator_isolate_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        instr_last_clk_i,
    input  wire logic        halt_fetched_i,
    input  wire logic        irq_enable_latch_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [15:0] sp_i,
    input  wire logic [7:0]  int_page_i,
    input  wire logic [15:0] refresh_addr_i,
    output logic [15:0]      address_o,
    output logic             address_oe_o,
    output logic [7:0]       data_o,
    output logic             data_oe_o,
    output logic             fetch_cycle_n_o,
    output logic             memory_cycle_strobe_n_o,
    output logic             io_cycle_strobe_n_o,
    output logic             read_strobe_n_o,
    output logic             write_strobe_n_o,
    output logic             strobe_oe_o,
    output logic             refresh_strobe_n_o,
    output logic             halted_n_o,
    output logic             halted_oe_o,
    output logic             seq_busy_o,
    output logic             pc_load_o,
    output logic [15:0]      pc_value_o,
    output logic             stack_adjust_o
);

    seq_state_t        r_reg;
    seq_state_t        r_next;
    logic [SYNC_W-1:0] pins_s;
    logic [7:0]        data_s;
    logic              irq_n_s;
    logic              nmi_n_s;
    logic              stall_n_s;
    logic              busrq_n_s;
    logic              iso_s;
    logic              nmi_fall;
    logic              irq_ok;
    logic              sample_pt;
    logic              take_nmi;
    logic              take_irq;
    logic              take;
    logic              in_fetch;
    logic              irq_fetch;
    logic              early;
    logic              float_bus;

    pin_sync pin_sync_i (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     ({emulator_isolate_i, bus_takeover_request_n_i, stall_request_n_i,
                      nmi_request_n_i, irq_request_n_i, data_i}),
        .pins_o     (pins_s)
    );

    assign data_s    = pins_s[SYNC_DATA_LSB +: 8];
    assign irq_n_s   = pins_s[SYNC_IRQ_BIT];
    assign nmi_n_s   = pins_s[SYNC_NMI_BIT];
    assign stall_n_s = pins_s[SYNC_STALL_BIT];
    assign busrq_n_s = pins_s[SYNC_BUSRQ_BIT];
    assign iso_s     = pins_s[SYNC_ISO_BIT];

    assign nmi_fall  = r_reg.nmi_prev & ~nmi_n_s;
    assign irq_ok    = ~irq_n_s & irq_enable_latch_i & busrq_n_s;
    assign sample_pt = ((r_reg.state == ST_IDLE) & instr_last_clk_i)
                     | ((r_reg.state == ST_T4) & (r_reg.kind == KIND_HALT));
    assign take_nmi  = r_reg.nmi_pend;
    assign take_irq  = irq_ok & ~take_nmi;
    assign take      = sample_pt & (take_nmi | take_irq);

    always_comb begin
        r_next              = r_reg;
        r_next.pc_load      = 1'b0;
        r_next.stack_adjust = 1'b0;
        r_next.nmi_prev     = nmi_n_s;
        // a new edge in the clearing cycle is kept
        r_next.nmi_pend     = (r_reg.nmi_pend & ~(sample_pt & take_nmi)) | nmi_fall;
        unique case (r_reg.state)
            ST_IDLE: begin
                if (halt_fetched_i) begin
                    r_next.halted = 1'b1;
                    r_next.kind   = KIND_HALT;
                    r_next.mcyc   = MC_FETCH;
                    r_next.state  = ST_T1;
                end
            end
            ST_DUMMY: begin
                if (r_reg.dummy_cnt == RESET_DUMMY_STATES - 2'h1) begin
                    r_next.pc_load  = 1'b1;
                    r_next.pc_value = RESET_START_ADDR;
                    r_next.state    = ST_IDLE;
                end else begin
                    r_next.dummy_cnt = 2'(r_reg.dummy_cnt + 2'h1);
                end
            end
            ST_T1: begin
                r_next.state = ST_T2;
            end
            ST_T2: begin
                if (r_reg.mcyc == MC_FETCH && r_reg.kind == KIND_IRQ) begin
                    r_next.state = ST_TWA;
                end else if (r_reg.mcyc == MC_LOAD || stall_n_s) begin
                    r_next.state = ST_T3;
                end else begin
                    r_next.state = ST_TW;
                end
            end
            ST_TWA: begin
                r_next.state = ST_TWB;
            end
            ST_TWB, ST_TW: begin
                r_next.state = stall_n_s ? ST_T3 : ST_TW;
            end
            ST_T3: begin
                if (r_reg.mcyc == MC_FETCH) begin
                    r_next.state = ST_T4;
                    // nmi and halt fetches drop the byte
                    if (r_reg.kind == KIND_IRQ) begin
                        r_next.vector = data_s;
                    end
                end else begin
                    r_next.state = ST_T1;
                    unique case (r_reg.mcyc)
                        MC_PUSH_HI: begin
                            r_next.mcyc = MC_PUSH_LO;
                        end
                        MC_PUSH_LO: begin
                            r_next.stack_adjust = 1'b1;
                            if (r_reg.kind == KIND_NMI) begin
                                r_next.pc_load  = 1'b1;
                                r_next.pc_value = NMI_VECTOR_ADDR;
                                r_next.kind     = KIND_NONE;
                                r_next.mcyc     = MC_FETCH;
                                r_next.state    = ST_IDLE;
                            end else begin
                                r_next.mcyc = MC_VEC_RD;
                            end
                        end
                        MC_VEC_RD: begin
                            r_next.vec_byte = data_s;
                            r_next.mcyc     = MC_LOAD;
                        end
                        default: begin
                            r_next.pc_load  = 1'b1;
                            r_next.pc_value = {int_page_i, r_reg.vec_byte};
                            r_next.kind     = KIND_NONE;
                            r_next.mcyc     = MC_FETCH;
                            r_next.state    = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_T4: begin
                r_next.state = ST_T1;
                if (r_reg.kind != KIND_HALT) begin
                    r_next.mcyc = MC_PUSH_HI;
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase
        if (take) begin
            r_next.kind   = take_nmi ? KIND_NMI : KIND_IRQ;
            r_next.mcyc   = MC_FETCH;
            r_next.state  = ST_T1;
            r_next.halted = 1'b0;
        end
        // address and write data are registered from the next cycle's position
        r_next.dout = 8'h00;
        if ((r_next.state == ST_T3 || r_next.state == ST_T4) && r_next.mcyc == MC_FETCH) begin
            r_next.addr = refresh_addr_i;
        end else begin
            unique case (r_next.mcyc)
                MC_PUSH_HI: begin
                    r_next.addr = sp_i - STACK_STEP;
                    r_next.dout = pc_i[15:8];
                end
                MC_PUSH_LO: begin
                    r_next.addr = sp_i - STACK_STEP - STACK_STEP;
                    r_next.dout = pc_i[7:0];
                end
                MC_VEC_RD: begin
                    r_next.addr = {int_page_i, r_next.vector};
                end
                default: begin
                    r_next.addr = pc_i;
                end
            endcase
        end
    end

    // reset also clears halt and the pending latch
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            r_reg <= SEQ_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign early     = r_reg.state == ST_T1 || r_reg.state == ST_T2 || r_reg.state == ST_TW;
    assign in_fetch  = r_reg.mcyc == MC_FETCH && r_reg.state != ST_IDLE
                     && r_reg.state != ST_DUMMY;
    assign irq_fetch = in_fetch && r_reg.kind == KIND_IRQ;
    assign float_bus = iso_s & ~busrq_n_s;

    always_comb begin
        fetch_cycle_n_o         = ~(in_fetch && (early || r_reg.state == ST_TWA
                                  || r_reg.state == ST_TWB));
        memory_cycle_strobe_n_o = ~((in_fetch && !irq_fetch && early)
                                  || (in_fetch && r_reg.state == ST_T3)
                                  || (!in_fetch && early && r_reg.mcyc != MC_LOAD
                                      && r_reg.state != ST_IDLE));
        io_cycle_strobe_n_o     = ~(irq_fetch && (r_reg.state == ST_TWA
                                  || r_reg.state == ST_TWB || r_reg.state == ST_TW));
        read_strobe_n_o         = ~(((in_fetch && !irq_fetch)
                                  || r_reg.mcyc == MC_VEC_RD) && early);
        write_strobe_n_o        = ~((r_reg.mcyc == MC_PUSH_HI || r_reg.mcyc == MC_PUSH_LO)
                                  && (r_reg.state == ST_T2 || r_reg.state == ST_TW));
        refresh_strobe_n_o      = ~(in_fetch && (r_reg.state == ST_T3
                                  || r_reg.state == ST_T4));
    end

    assign seq_busy_o     = r_reg.state != ST_IDLE;
    assign address_o      = r_reg.addr;
    assign data_o         = r_reg.dout;
    // sequencer drives address and strobe pins only while busy and not floated; data pins only during the two pushes
    assign address_oe_o   = seq_busy_o & ~float_bus;
    assign strobe_oe_o    = seq_busy_o & ~float_bus;
    assign data_oe_o      = (r_reg.mcyc == MC_PUSH_HI || r_reg.mcyc == MC_PUSH_LO)
                          & seq_busy_o & ~float_bus;
    assign halted_oe_o    = ~float_bus;
    assign halted_n_o     = ~r_reg.halted;
    assign pc_load_o      = r_reg.pc_load;
    assign pc_value_o     = r_reg.pc_value;
    assign stack_adjust_o = r_reg.stack_adjust;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    refuse_irq_a: assert property (
        sample_pt && !r_reg.nmi_pend && (!irq_enable_latch_i || !busrq_n_s)
        |=> r_reg.kind != KIND_IRQ
    ) else $error("maskable request accepted while refused");
    auto_wait_a: assert property (
        r_reg.state == ST_T2 && irq_fetch |=> r_reg.state == ST_TWA ##1 r_reg.state == ST_TWB
    ) else $error("acknowledge fetch lacks two automatic waits");
    stall_wait_a: assert property (
        (r_reg.state == ST_TWB || r_reg.state == ST_TW) && !stall_n_s |=> r_reg.state == ST_TW
    ) else $error("stall not honoured");
    io_strobe_a: assert property (
        irq_fetch && r_reg.state == ST_TWA |-> !io_cycle_strobe_n_o && memory_cycle_strobe_n_o
    ) else $error("acknowledge strobes wrong");
    read_high_a: assert property (
        irq_fetch |-> read_strobe_n_o
            && fetch_cycle_n_o == !(early || r_reg.state == ST_TWA || r_reg.state == ST_TWB)
    ) else $error("read strobe during acknowledge");
    refresh_t3_a: assert property (
        in_fetch && r_reg.state == ST_T3
        |-> !refresh_strobe_n_o && address_o == $past(refresh_addr_i)
    ) else $error("refresh missing in T3");
    push_order_a: assert property (
        r_reg.state == ST_T3 && r_reg.mcyc == MC_PUSH_HI
        |=> r_reg.mcyc == MC_PUSH_LO && r_reg.state == ST_T1 && data_o == $past(pc_i[7:0])
    ) else $error("push order broken");
    vec_load_a: assert property (
        r_reg.state == ST_T3 && r_reg.mcyc == MC_LOAD
        |=> pc_load_o && pc_value_o == {$past(int_page_i), $past(r_reg.vec_byte)}
    ) else $error("vector load wrong");
    nmi_latch_a: assert property (
        nmi_fall |=> r_reg.nmi_pend
    ) else $error("unmaskable edge lost");
    nmi_jump_a: assert property (
        r_reg.state == ST_T3 && r_reg.mcyc == MC_PUSH_LO && r_reg.kind == KIND_NMI
        |=> pc_load_o && pc_value_o == NMI_VECTOR_ADDR && stack_adjust_o
    ) else $error("unmaskable jump wrong");
    halt_low_a: assert property (
        r_reg.state == ST_IDLE && halt_fetched_i && !take |=> !halted_n_o
    ) else $error("halted indicator late");
    halt_loop_a: assert property (
        r_reg.state == ST_T4 && r_reg.kind == KIND_HALT && !take
        |=> r_reg.state == ST_T1 && r_reg.kind == KIND_HALT && !halted_n_o
    ) else $error("halt loop broken");
    halt_wake_a: assert property (
        r_reg.state == ST_T4 && r_reg.kind == KIND_HALT && take
        |=> halted_n_o && r_reg.state == ST_T1 && r_reg.kind != KIND_HALT
    ) else $error("halt wake wrong");
    accept_irq_a: assert property (
        sample_pt && irq_ok && !r_reg.nmi_pend |=> r_reg.kind == KIND_IRQ && r_reg.state == ST_T1
    ) else $error("maskable request not accepted");
    float_bus_a: assert property (
        iso_s && !busrq_n_s |-> !address_oe_o && !data_oe_o && !strobe_oe_o && !halted_oe_o
    ) else $error("bus not floated");

    reset_start_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        $past(!reset_n_i) && reset_n_i
        |-> r_reg.state == ST_DUMMY ##1 r_reg.state == ST_DUMMY
            ##1 (pc_load_o && pc_value_o == RESET_START_ADDR && reset_n_i)
            or ##[0:2] !reset_n_i
    ) else $error("reset start sequence wrong");

    irq_seq_c:  cover property (r_reg.mcyc == MC_LOAD && r_reg.state == ST_T3);
    nmi_seq_c:  cover property (r_reg.kind == KIND_NMI && r_reg.mcyc == MC_PUSH_LO);
    halt_wake_c: cover property (r_reg.kind == KIND_HALT && take);
    float_c:    cover property (float_bus && seq_busy_o);

endmodule

/* design/seq_pkg.sv */
package seq_pkg;

    // bus state per clock state; one-bit steps along T1, T2, TWA, TWB, TW, T3, T4
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_DUMMY = 4'h1,
        ST_T1    = 4'h3,
        ST_T2    = 4'h2,
        ST_TWA   = 4'h6,
        ST_TWB   = 4'h7,
        ST_TW    = 4'h5,
        ST_T3    = 4'h4,
        ST_T4    = 4'hc
    } bus_state_t;

    typedef enum logic [1:0] {
        KIND_NONE = 2'h0,
        KIND_IRQ  = 2'h1,
        KIND_NMI  = 2'h3,
        KIND_HALT = 2'h2
    } seq_kind_t;

    typedef enum logic [2:0] {
        MC_FETCH   = 3'h0,
        MC_PUSH_HI = 3'h1,
        MC_PUSH_LO = 3'h3,
        MC_VEC_RD  = 3'h2,
        MC_LOAD    = 3'h6
    } mcycle_t;

    localparam logic [1:0]  RESET_DUMMY_STATES = 2'h2;
    localparam logic [15:0] NMI_VECTOR_ADDR    = 16'h0066;
    localparam logic [15:0] RESET_START_ADDR   = 16'h0000;
    localparam logic [15:0] STACK_STEP         = 16'h0001;

    // synchroniser lanes: {isolate, takeover_n, stall_n, nmi_n, irq_n, data[7:0]}
    localparam int          SYNC_W         = 13;
    localparam logic [12:0] SYNC_RESET_VAL = 13'h0f00;
    localparam int          SYNC_DATA_LSB  = 0;
    localparam int          SYNC_IRQ_BIT   = 8;
    localparam int          SYNC_NMI_BIT   = 9;
    localparam int          SYNC_STALL_BIT = 10;
    localparam int          SYNC_BUSRQ_BIT = 11;
    localparam int          SYNC_ISO_BIT   = 12;

    typedef struct packed {
        bus_state_t  state;
        seq_kind_t   kind;
        mcycle_t     mcyc;
        logic [1:0]  dummy_cnt;
        logic        halted;
        logic        nmi_pend;
        logic        nmi_prev;
        logic [7:0]  vector;
        logic [7:0]  vec_byte;
        logic [15:0] addr;
        logic [7:0]  dout;
        logic        pc_load;
        logic [15:0] pc_value;
        logic        stack_adjust;
    } seq_state_t;

    localparam seq_state_t SEQ_RESET = '{
        state:        ST_DUMMY,
        kind:         KIND_NONE,
        mcyc:         MC_FETCH,
        dummy_cnt:    2'h0,
        halted:       1'b0,
        nmi_pend:     1'b0,
        nmi_prev:     1'b1,
        vector:       8'h00,
        vec_byte:     8'h00,
        addr:         16'h0000,
        dout:         8'h00,
        pc_load:      1'b0,
        pc_value:     16'h0000,
        stack_adjust: 1'b0
    };

endpackage

/* design/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
    import seq_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [SYNC_W-1:0] pins_i,
    output logic      [SYNC_W-1:0] pins_o
);

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } sync_state_t;

    sync_state_t r_reg;
    sync_state_t r_next;

    // stage1 is read only by stage2
    always_comb begin
        r_next        = r_reg;
        r_next.stage1 = pins_i;
        r_next.stage2 = r_reg.stage1;
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            r_reg <= '{stage1: SYNC_RESET_VAL, stage2: SYNC_RESET_VAL};
        end else begin
            r_reg <= r_next;
        end
    end

    assign pins_o = r_reg.stage2;

endmodule

/* sim/bus_peer.sv */
`timescale 1ns/1ns
module bus_peer (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] address_i,
    input  wire logic        mem_strobe_n_i,
    input  wire logic        io_strobe_n_i,
    input  wire logic        read_n_i,
    input  wire logic [7:0]  vector_i,
    output logic      [7:0]  data_o
);
    logic [1:0] hold_reg = 2'h0;
    logic [7:0] last_reg = 8'h00;
    logic       drive;
    logic [7:0] byte_now;
    // memory byte derived from address so the bench can predict it
    always_comb begin
        drive    = !io_strobe_n_i || (!mem_strobe_n_i && !read_n_i);
        byte_now = !io_strobe_n_i ? vector_i : (address_i[7:0] ^ 8'h5a);
        data_o   = drive ? byte_now : ((hold_reg != 2'h0) ? last_reg : ~last_reg);
    end
    // held through t3: the core sees data through a two-flop synchroniser
    always_ff @(posedge core_clk_i) begin
        if (drive) begin
            last_reg <= byte_now;
            hold_reg <= 2'h3;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end
endmodule

/* sim/tb_cpu_irq_halt_reset_sequencer.sv */
`timescale 1ns/1ns
module tb_cpu_irq_halt_reset_sequencer;
    import seq_pkg::*;
    logic        core_clk_i, reset_n_i, irq_request_n_i, nmi_request_n_i, stall_request_n_i;
    logic        bus_takeover_request_n_i, emulator_isolate_i, instr_last_clk_i, halt_fetched_i;
    logic        irq_enable_latch_i, address_oe_o, data_oe_o, fetch_cycle_n_o, strobe_oe_o;
    logic        memory_cycle_strobe_n_o, io_cycle_strobe_n_o, read_strobe_n_o, halted_oe_o;
    logic        write_strobe_n_o, refresh_strobe_n_o, halted_n_o, seq_busy_o, pc_load_o;
    logic        stack_adjust_o, wr_prev;
    logic [7:0]  data_i, data_o, int_page_i;
    logic [15:0] pc_i, sp_i, refresh_addr_i, address_o, pc_value_o;
    logic [23:0] wr_q[$];
    int          n_fail, check_count, io_cnt, rd_bad, refresh_strobe_n_cnt, adj_cnt, fc_cnt;
    localparam logic [7:0] VEC = 8'h10;
    cpu_irq_halt_reset_sequencer cpu_irq_halt_reset_sequencer_i (.core_clk_i, .reset_n_i,
        .irq_request_n_i, .nmi_request_n_i, .stall_request_n_i, .bus_takeover_request_n_i,
        .emulator_isolate_i, .data_i, .instr_last_clk_i, .halt_fetched_i, .irq_enable_latch_i,
        .pc_i, .sp_i, .int_page_i, .refresh_addr_i, .address_o, .address_oe_o, .data_o,
        .data_oe_o, .fetch_cycle_n_o, .memory_cycle_strobe_n_o, .io_cycle_strobe_n_o,
        .read_strobe_n_o, .write_strobe_n_o, .strobe_oe_o, .refresh_strobe_n_o, .halted_n_o,
        .halted_oe_o, .seq_busy_o, .pc_load_o, .pc_value_o, .stack_adjust_o);
    bus_peer bus_peer_i (.core_clk_i, .address_i(address_o),
        .mem_strobe_n_i(memory_cycle_strobe_n_o), .io_strobe_n_i(io_cycle_strobe_n_o),
        .read_n_i(read_strobe_n_o), .vector_i(VEC), .data_o(data_i));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse_last();
        @(posedge core_clk_i);
        instr_last_clk_i <= 1'b1;
        @(posedge core_clk_i);
        instr_last_clk_i <= 1'b0;
    endtask
    // first look is the cycle just after the accept edge, so T1 is counted too;
    // bounded so that a hang ends as a mismatch rather than a stall
    task automatic watch();
        int n;
        n = 0;
        {io_cnt, rd_bad, refresh_strobe_n_cnt, adj_cnt, fc_cnt} = '0;
        wr_q.delete();
        wr_prev = 1'b1;
        #1;
        while (n < 80) begin
            io_cnt += (io_cycle_strobe_n_o === 1'b0);
            rd_bad += (io_cycle_strobe_n_o === 1'b0
                       && {read_strobe_n_o, memory_cycle_strobe_n_o} !== 2'h3);
            refresh_strobe_n_cnt += (refresh_strobe_n_o === 1'b0 && address_o === refresh_addr_i);
            fc_cnt += (fetch_cycle_n_o === 1'b0);
            if (write_strobe_n_o === 1'b0 && wr_prev) wr_q.push_back({address_o, data_o});
            wr_prev = write_strobe_n_o;
            adj_cnt += (stack_adjust_o === 1'b1);
            if (pc_load_o === 1'b1) break;
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check(pc_load_o, 1'b1);
    endtask
    task automatic check_push();
        check(wr_q.size(), 2);
        check(wr_q[0], {sp_i - 16'h0001, pc_i[15:8]});
        check(wr_q[1], {sp_i - 16'h0002, pc_i[7:0]});
        check(adj_cnt, 1);
    endtask
    task automatic test_irq(input bit stall);
        @(posedge core_clk_i);
        irq_request_n_i <= 1'b0;
        stall_request_n_i <= !stall;
        repeat (4) @(posedge core_clk_i);
        pulse_last();
        irq_request_n_i <= 1'b1;
        fork
            watch();
            begin
                wait (io_cycle_strobe_n_o === 1'b0);
                repeat (5) @(posedge core_clk_i);
                stall_request_n_i <= 1'b1;
            end
        join
        if (stall) check(io_cnt > 2, 1);
        else check(io_cnt, 2);
        check(fc_cnt, io_cnt + 2);
        check(rd_bad, 0);
        check(refresh_strobe_n_cnt != 0, 1);
        check_push();
        check(pc_value_o, {int_page_i, VEC ^ 8'h5a});
        $display("test irq stall=%0d done", stall);
    endtask
    task automatic test_refuse();
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_i);
            irq_enable_latch_i <= (k == 1);
            bus_takeover_request_n_i <= (k == 0);
            emulator_isolate_i <= (k == 1);
            irq_request_n_i <= 1'b0;
            repeat (4) @(posedge core_clk_i);
            pulse_last();
            repeat (3) @(posedge core_clk_i);
            #1;
            check(seq_busy_o, 1'b0);
            if (k == 1) check({halted_oe_o, strobe_oe_o, address_oe_o, data_oe_o}, 4'h0);
        end
        @(posedge core_clk_i);
        {irq_request_n_i, bus_takeover_request_n_i, emulator_isolate_i} <= 3'h6;
        repeat (4) @(posedge core_clk_i);
        #1;
        check(halted_oe_o, 1'b1);
        $display("test refuse done");
    endtask
    task automatic test_nmi();
        @(posedge core_clk_i);
        nmi_request_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        nmi_request_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        pulse_last();
        watch();
        check(io_cnt, 0);
        check(fc_cnt, 2);
        check_push();
        check(pc_value_o, NMI_VECTOR_ADDR);
        $display("test nmi done");
    endtask
    task automatic test_halt();
        @(posedge core_clk_i);
        halt_fetched_i <= 1'b1;
        @(posedge core_clk_i);
        halt_fetched_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        #1;
        check(halted_n_o, 1'b0);
        @(posedge core_clk_i);
        irq_request_n_i <= 1'b0;
        watch();
        irq_request_n_i <= 1'b1;
        check(refresh_strobe_n_cnt > 1, 1);
        check(io_cnt, 2);
        check({halted_n_o, pc_value_o}, {1'b1, int_page_i, VEC ^ 8'h5a});
        $display("test halt done");
    endtask
    // halted core woken by a short reset instead of an interrupt
    task automatic test_wake_reset();
        @(posedge core_clk_i);
        halt_fetched_i <= 1'b1;
        @(posedge core_clk_i);
        halt_fetched_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        watch();
        check({halted_n_o, pc_value_o}, {1'b1, RESET_START_ADDR});
        $display("test wake reset done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
    initial begin
        {n_fail, check_count} = '0;
        {reset_n_i, instr_last_clk_i, halt_fetched_i, emulator_isolate_i} = 4'h0;
        {irq_request_n_i, nmi_request_n_i, stall_request_n_i, bus_takeover_request_n_i} = 4'hf;
        {irq_enable_latch_i, pc_i, sp_i, int_page_i} = {1'b1, 16'h1234, 16'h8000, 8'h3c};
        refresh_addr_i = 16'h3c55;
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        watch();
        check(pc_value_o, RESET_START_ADDR);
        $display("test reset done");
        test_irq(1'b0);
        test_irq(1'b1);
        test_refuse();
        test_nmi();
        test_halt();
        test_wake_reset();
        final_report();
    end
endmodule
